//--- core/pot_link_pkg.sv
// Purpose: shared constants for the two-wire potentiometer link
// Assumes: 10 MHz system clock on both ends
// Notes:   one definition per number; ends use pot_link_pkg::name
package pot_link_pkg;
   // link addressing and byte framing
   localparam logic [5:0] DEV_ADDR       = 6'h16;  // 010110
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   localparam logic [3:0] ACK_SLOT       = 4'h8;
   localparam int         INSTR_PROG_BIT = 7;

   // wiper code after reset: midscale
   localparam logic [5:0] WIPER_RESET    = 6'h20;

   // fuse status encodings
   localparam logic [1:0] FUSE_READY     = 2'h0;
   localparam logic [1:0] FUSE_TEST_FAIL = 2'h1;
   localparam logic [1:0] FUSE_FATAL     = 2'h2;
   localparam logic [1:0] FUSE_DONE      = 2'h3;

   // timing: serial clock made by the master's divider
   localparam int CLK_PERIOD_NS  = 100;
   localparam int SCL_PERIOD_NS  = 800;
   localparam int QUARTER_RAW    = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
   localparam int QUARTER_CYCLES = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;

   // master register map, byte addresses
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] CODE_OFS   = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;

   // field positions
   localparam int CTRL_GO_BIT   = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int CTRL_PROG_BIT = 2;
   localparam int CTRL_SEL_BIT  = 3;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_RX_LSB   = 8;

   // register reset values
   localparam logic [5:0] CODE_RESET = 6'h20;
endpackage

//--- core/pot_link_if.sv
// Purpose: open-drain two-wire link between master and slave
// Assumes: pull-ups modelled by resolving the enables
// Notes:   a line is low while any enabled driver outputs low
`timescale 1ns/1ps
interface pot_link_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;

   // wired-and resolution with pull-up
   assign scl = !(scl_oe && !scl_o);
   assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);

   modport master (
      output scl_o,
      output scl_oe,
      output m_sda_o,
      output m_sda_oe,
      input  scl,
      input  sda
   );

   modport slave (
      input  scl,
      input  sda,
      output d_sda_o,
      output d_sda_oe
   );
endinterface

//--- core/pot_slave.sv
// Purpose: serial slave front end of a 64-step one-time-programmable pot
// Assumes: scl slower than a quarter of clock_i; master drives scl
// Notes:   fuse blowing itself lives outside; we only request it
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module pot_slave (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   pot_link_if.slave       link,
   input  wire logic       addr_select_pin_i,
   input  wire logic [1:0] fuse_status_bits_i,
   output logic      [5:0] wiper_setting_o,
   output logic            fuse_program_o,
   output logic            addressed_o
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_INSTR,
      ST_DATA,
      ST_READ,
      ST_SKIP
   } slave_state_t;

   slave_state_t state_r;
   logic [3:0]   cnt_r;
   logic         ack_r;
   logic [7:0]   shift_r;
   logic [7:0]   tx_r;
   logic         prog_r;
   logic         drive_r;
   logic [5:0]   wiper_r;
   logic         fuse_pulse_r;

   logic scl_s1;
   logic scl_s2;
   logic scl_d;
   logic sda_s1;
   logic sda_s2;
   logic sda_d;
   logic sel_s1;
   logic sel_s2;
   logic [1:0] fuse_s1;
   logic [1:0] fuse_s2;

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic rx_state;
   logic byte_end;
   logic addr_hit;
   logic take_ack;
   logic ack_end;
   logic data_take;
   logic locked;
   logic may_fuse;
   logic rd_next;

   // two-flop synchronisers plus one delay stage for edges
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= link.scl;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   // slow pins: select strap and fuse status
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sel_s1  <= 1'b0;
         sel_s2  <= 1'b0;
         fuse_s1 <= pot_link_pkg::FUSE_READY;
         fuse_s2 <= pot_link_pkg::FUSE_READY;
      end else begin
         sel_s1  <= addr_select_pin_i;
         sel_s2  <= sel_s1;
         fuse_s1 <= fuse_status_bits_i;
         fuse_s2 <= fuse_s1;
      end
   end

   // bus events, all from synchronised copies
   always_comb begin
      scl_rise  = scl_s2 && !scl_d;
      scl_fall  = !scl_s2 && scl_d;
      // start: data falls while clock high
      start_det = scl_s2 && scl_d && sda_d && !sda_s2;
      // stop: data rises while clock high
      stop_det  = scl_s2 && scl_d && !sda_d && sda_s2;
      rx_state  = (state_r == ST_ADDR) || (state_r == ST_INSTR) ||
                  (state_r == ST_DATA);
      // eight bits in, ack slot follows
      byte_end  = scl_fall && !ack_r && rx_state &&
                  (cnt_r == pot_link_pkg::BITS_PER_BYTE);
      // fixed six bits then the select pin level
      addr_hit  = (shift_r[7:1] ==
                   {pot_link_pkg::DEV_ADDR, sel_s2});
      take_ack  = byte_end && ((state_r != ST_ADDR) || addr_hit);
      ack_end   = scl_fall && ack_r;
      data_take = byte_end && (state_r == ST_DATA);
      locked    = (fuse_s2 == pot_link_pkg::FUSE_DONE);
      may_fuse  = (fuse_s2 == pot_link_pkg::FUSE_READY);
      rd_next   = (state_r == ST_ADDR) && shift_r[0];
   end

   // transfer sequencing: address, instruction, data or read
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= 4'h0;
         ack_r   <= 1'b0;
      end else if (start_det) begin
         state_r <= ST_ADDR;
         cnt_r   <= 4'h0;
         ack_r   <= 1'b0;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
         cnt_r   <= 4'h0;
         ack_r   <= 1'b0;
      end else if (scl_rise && !ack_r &&
                   (rx_state || state_r == ST_READ)) begin
         cnt_r <= cnt_r + 4'h1;
      end else if (byte_end) begin
         if (take_ack) begin
            ack_r <= 1'b1;
         end else begin
            state_r <= ST_SKIP;
         end
      end else if (ack_end) begin
         ack_r <= 1'b0;
         cnt_r <= 4'h0;
         case (state_r)
            ST_ADDR: begin
               // direction bit picks the path
               state_r <= rd_next ? ST_READ : ST_INSTR;
            end
            ST_INSTR: begin
               state_r <= ST_DATA;
            end
            ST_DATA: begin
               // more data bytes reuse the instruction
               state_r <= ST_DATA;
            end
            default: begin
               state_r <= ST_SKIP;
            end
         endcase
      end else if (scl_fall && state_r == ST_READ &&
                   cnt_r == pot_link_pkg::BITS_PER_BYTE) begin
         // master's ninth slot is its not-acknowledge
         state_r <= ST_SKIP;
      end
   end

   // receive shifter, msb first on rising clock
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         shift_r <= 8'h00;
      end else if (start_det) begin
         shift_r <= 8'h00;
      end else if (scl_rise && !ack_r && rx_state) begin
         shift_r <= {shift_r[6:0], sda_s2};
      end
   end

   // instruction flag held for the whole write transfer
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         prog_r <= 1'b0;
      end else if (start_det) begin
         prog_r <= 1'b0;
      end else if (take_ack && state_r == ST_INSTR) begin
         // other seven bits ignored
         prog_r <= shift_r[pot_link_pkg::INSTR_PROG_BIT];
      end
   end

   // wiper latch, midscale out of reset
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wiper_r <= pot_link_pkg::WIPER_RESET;
      end else if (data_take && !locked) begin
         wiper_r <= shift_r[5:0];
      end
   end

   // one-cycle fuse request with the new code
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         fuse_pulse_r <= 1'b0;
      end else begin
         fuse_pulse_r <= data_take && prog_r && may_fuse;
      end
   end

   // data line drive: ack slots and read bits, open drain
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         drive_r <= 1'b0;
         tx_r    <= 8'h00;
      end else if (start_det || stop_det) begin
         drive_r <= 1'b0;
      end else if (take_ack) begin
         drive_r <= 1'b1;
      end else if (ack_end) begin
         if (rd_next) begin
            // status and wiper go out straight after ack
            tx_r    <= {fuse_s2, wiper_r};
            drive_r <= !fuse_s2[1];
         end else begin
            drive_r <= 1'b0;
         end
      end else if (scl_fall && state_r == ST_READ) begin
         if (cnt_r < pot_link_pkg::BITS_PER_BYTE) begin
            tx_r    <= {tx_r[6:0], 1'b0};
            drive_r <= !tx_r[6];
         end else begin
            drive_r <= 1'b0;
         end
      end
   end

   // only pull low; the clock line is never touched
   assign link.d_sda_o    = 1'b0;
   assign link.d_sda_oe   = drive_r;
   assign wiper_setting_o = wiper_r;
   assign fuse_program_o  = fuse_pulse_r;
   assign addressed_o     = (state_r != ST_IDLE) && (state_r != ST_SKIP);

endmodule

//--- core/pot_master.sv
// Purpose: two-wire master driving the pot, commanded over Avalon-MM
// Assumes: software waits for busy low before a new go
// Notes:   scl comes from a quarter-period divider of clock_i
`timescale 1ns/1ps
module pot_master #(
   parameter int QUARTER = pot_link_pkg::QUARTER_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   pot_link_if.master       link
);

   typedef enum logic [1:0] {
      M_IDLE,
      M_START,
      M_BIT,
      M_STOP
   } master_state_t;

   master_state_t state_r;
   logic [5:0]  code_r;
   logic        rd_r;
   logic        prog_r;
   logic        sel_r;
   logic        nack_r;
   logic [7:0]  rx_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic [7:0]  qcnt_r;
   logic [1:0]  q_r;
   logic [3:0]  bit_r;
   logic [1:0]  byte_r;
   logic        scl_oe_r;
   logic        sda_oe_r;
   logic        sda_s1;
   logic        sda_s2;
   logic        tick;
   logic        go;
   logic        busy;
   logic        wr_en;
   logic        recv;
   logic        bitval;
   logic [7:0]  txb;
   logic [1:0]  last_byte;

   // byte sent at each position of the transfer
   function automatic logic [7:0] tx_byte(input logic [1:0] idx,
                                          input logic rd, input logic pr,
                                          input logic sl,
                                          input logic [5:0] cd);
      logic [7:0] b;
      b = 8'hff;
      if (idx == 2'h0) begin
         b = {pot_link_pkg::DEV_ADDR, sl, rd};
      end else if (idx == 2'h1 && !rd) begin
         b = {pr, 7'h00};
      end else if (idx == 2'h2) begin
         b = {2'h0, cd};
      end
      return b;
   endfunction

   // bus handshake: every access waits one cycle
   always_comb begin
      avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
      wr_en     = avs_write_i && ack_r;
      busy      = (state_r != M_IDLE);
      go        = wr_en && (avs_address_i == pot_link_pkg::CTRL_OFS) &&
                  avs_writedata_i[pot_link_pkg::CTRL_GO_BIT] && !busy;
      tick      = busy && (qcnt_r == 8'(QUARTER - 1));
      recv      = rd_r && (byte_r == 2'h1);
      txb       = tx_byte(byte_r, rd_r, prog_r, sel_r, code_r);
      bitval    = (bit_r >= pot_link_pkg::ACK_SLOT) || recv ||
                  txb[3'(4'h7 - bit_r)];
      last_byte = rd_r ? 2'h1 : 2'h2;
   end

   // access acknowledge and read data
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
         if (avs_read_i && !ack_r) begin
            case (avs_address_i)
               pot_link_pkg::CTRL_OFS:   rdata_r <= {28'h0, sel_r, prog_r,
                                                     rd_r, 1'b0};
               pot_link_pkg::CODE_OFS:   rdata_r <= {26'h0, code_r};
               pot_link_pkg::STATUS_OFS: rdata_r <= {16'h0, rx_r, 6'h0,
                                                     nack_r, busy};
               default:                  rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // command registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         code_r <= pot_link_pkg::CODE_RESET;
         rd_r   <= 1'b0;
         prog_r <= 1'b0;
         sel_r  <= 1'b0;
      end else if (wr_en && avs_address_i == pot_link_pkg::CODE_OFS) begin
         code_r <= avs_writedata_i[5:0];
      end else if (go) begin
         rd_r   <= avs_writedata_i[pot_link_pkg::CTRL_READ_BIT];
         prog_r <= avs_writedata_i[pot_link_pkg::CTRL_PROG_BIT];
         sel_r  <= avs_writedata_i[pot_link_pkg::CTRL_SEL_BIT];
      end
   end

   // data line synchroniser
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end else begin
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
      end
   end

   // quarter-period divider
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || !busy || tick) begin
         qcnt_r <= 8'h00;
      end else begin
         qcnt_r <= qcnt_r + 8'h01;
      end
   end

   // link sequencer: start, bits with ack slots, stop
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_r  <= M_IDLE;
         q_r      <= 2'h0;
         bit_r    <= 4'h0;
         byte_r   <= 2'h0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         nack_r   <= 1'b0;
         rx_r     <= 8'h00;
      end else if (go) begin
         state_r <= M_START;
         q_r     <= 2'h0;
         nack_r  <= 1'b0;
      end else if (tick) begin
         q_r <= q_r + 2'h1;
         case (state_r)
            M_START: begin
               if (q_r == 2'h0) begin
                  sda_oe_r <= 1'b1;
               end else begin
                  scl_oe_r <= 1'b1;
                  state_r  <= M_BIT;
                  q_r      <= 2'h0;
                  bit_r    <= 4'h0;
                  byte_r   <= 2'h0;
               end
            end
            M_BIT: begin
               case (q_r)
                  2'h0: sda_oe_r <= !bitval;
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: begin
                     if (bit_r < pot_link_pkg::ACK_SLOT) begin
                        if (recv) begin
                           rx_r <= {rx_r[6:0], sda_s2};
                        end
                     end else if (!recv && sda_s2) begin
                        nack_r <= 1'b1;
                     end
                  end
                  default: begin
                     scl_oe_r <= 1'b1;
                     if (bit_r == pot_link_pkg::ACK_SLOT) begin
                        bit_r  <= 4'h0;
                        byte_r <= byte_r + 2'h1;
                        if (byte_r == last_byte || nack_r) begin
                           state_r <= M_STOP;
                        end
                     end else begin
                        bit_r <= bit_r + 4'h1;
                     end
                  end
               endcase
            end
            M_STOP: begin
               case (q_r)
                  2'h0: sda_oe_r <= 1'b1;
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: sda_oe_r <= 1'b0;
                  default: state_r <= M_IDLE;
               endcase
            end
            default: begin
               state_r <= M_IDLE;
            end
         endcase
      end
   end

   assign avs_readdata_o = rdata_r;
   assign link.scl_o     = 1'b0;
   assign link.scl_oe    = scl_oe_r;
   assign link.m_sda_o   = 1'b0;
   assign link.m_sda_oe  = sda_oe_r;

endmodule

//--- tb/pot_link_checker.sv
// Purpose: wire-level checks on the two-wire pot link
// Assumes: both ends on clock_i; lines are registered outputs
// Notes:   counts scl rises from each start to place ack slots
`timescale 1ns/1ps
module pot_link_checker (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic scl_oe,
   input wire logic m_sda_oe,
   input wire logic d_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_q;
   logic       sda_q;
   logic       rd_r;
   logic       drove_r;
   logic       idle_r;
   logic [5:0] rises_r;
   wire        start_w = scl && scl_q && sda_q && !sda;
   wire        stop_w  = scl && scl_q && !sda_q && sda;
   wire        rise_w  = scl && !scl_q;

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // previous line levels
   always_ff @(posedge clock_i) begin
      scl_q <= rst_n_i ? scl : 1'b1;
      sda_q <= rst_n_i ? sda : 1'b1;
   end

   // scl rises since start, direction bit
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || start_w) begin
         rises_r <= 6'h00;
         rd_r    <= 1'b0;
      end else if (rise_w) begin
         rises_r <= (rises_r == 6'h3f) ? rises_r : rises_r + 6'h01;
         rd_r    <= (rises_r == 6'h07) ? sda : rd_r;
      end
   end

   // slave answered this transfer; bus idle since stop
   always_ff @(posedge clock_i) begin
      drove_r <= rst_n_i && !start_w && (drove_r || d_sda_oe);
      idle_r  <= !rst_n_i || stop_w || (idle_r && !start_w);
   end

   sequence stop_s;
      stop_w;
   endsequence
   sequence wr_ack_s;
      rise_w && drove_r && !rd_r && (rises_r == 6'h11 || rises_r == 6'h1a);
   endsequence
   sequence rd_nack_s;
      rise_w && rd_r && rises_r == 6'h11;
   endsequence

   a_no_slave_frame: assert property
      (start_w || stop_w |-> !d_sda_oe && $stable(d_sda_oe))
      else $error("slave took part in start or stop");
   a_slave_low_change: assert property ($changed(d_sda_oe) |-> !scl)
      else $error("slave sda changed while scl high");
   a_master_sda_hold: assert property
      ($changed(m_sda_oe) && scl && scl_q |-> start_w || stop_w)
      else $error("master sda moved in scl high");
   a_ack_ninth_pulse: assert property
      ($rose(d_sda_oe) && !drove_r |-> rises_r == 6'h08)
      else $error("first slave drive not in ninth slot");
   a_write_byte_ack: assert property (wr_ack_s |-> d_sda_oe)
      else $error("write byte not acknowledged");
   a_read_nack_free: assert property (rd_nack_s |-> !d_sda_oe)
      else $error("slave drove master nack slot");
   a_stop_released: assert property (stop_s |-> !d_sda_oe ##1 idle_r)
      else $error("slave still driving at stop");
   a_idle_quiet: assert property (idle_r |-> !d_sda_oe && !scl_oe)
      else $error("line driven while bus idle");
   a_frame_nine_bits: assert property
      (stop_s |-> rises_r % 6'd9 == 6'd1)
      else $error("transfer not whole nine-bit bytes");
endmodule

//--- tb/test_otp_pot_serial_slave.sv
// Purpose: master and pot slave joined, driven over Avalon-MM
// Assumes: 100 ns clock, quarter of 2 gives 800 ns scl
// Notes:   fuse status and select pin driven by the bench
`timescale 1ns/1ps
module test_otp_pot_serial_slave;
   logic        clock_i;
   logic        rst_n_i;
   logic [3:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        addr_select_pin_i;
   logic [1:0]  fuse_status_bits_i;
   logic [5:0]  wiper_setting_o;
   logic        fuse_program_o;
   logic        addressed_o;
   logic [31:0] st;
   logic [5:0]  prog_code;
   logic        addr_seen;
   logic [5:0]  codes [3] = '{6'h2a, 6'h00, 6'h3f};
   int          prog_cnt;
   int          miscompares;
   int          cmp_count;

   pot_link_if link ();

   pot_master #(.QUARTER(2)) u_pot_master (
      .clock_i           (clock_i),
      .rst_n_i           (rst_n_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .link              (link)
   );

   pot_slave u_pot_slave (
      .clock_i            (clock_i),
      .rst_n_i            (rst_n_i),
      .link               (link),
      .addr_select_pin_i  (addr_select_pin_i),
      .fuse_status_bits_i (fuse_status_bits_i),
      .wiper_setting_o    (wiper_setting_o),
      .fuse_program_o     (fuse_program_o),
      .addressed_o        (addressed_o)
   );

   pot_link_checker u_pot_link_checker (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .scl_oe   (link.scl_oe),
      .m_sda_oe (link.m_sda_oe),
      .d_sda_oe (link.d_sda_oe),
      .scl      (link.scl),
      .sda      (link.sda)
   );

   // system clock
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   // record program pulses and answered addressing
   always @(posedge clock_i) begin
      if (fuse_program_o === 1'b1) begin
         prog_cnt++;
         prog_code = wiper_setting_o;
      end
      if (addressed_o === 1'b1 && link.d_sda_oe === 1'b1) addr_seen = 1'b1;
   end

   task check(input logic [31:0] got, input logic [31:0] exp,
              input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   task bus_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= 1'b1;
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
   endtask

   task bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_read_i    <= 1'b1;
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
      d = avs_readdata_o;
      avs_read_i <= 1'b0;
   endtask

   // one link transfer, polled to completion
   task xfer(input logic rd, input logic pr, input logic sl,
             input logic [5:0] cd, output logic [31:0] s);
      bus_write(pot_link_pkg::CODE_OFS, {26'h0, cd});
      bus_write(pot_link_pkg::CTRL_OFS, {28'h0, sl, pr, rd, 1'b1});
      s = 32'h1;
      while (s[pot_link_pkg::STAT_BUSY_BIT] !== 1'b0)
         bus_read(pot_link_pkg::STATUS_OFS, s);
   endtask

   task do_reset;
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
   endtask

   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (60000) @(posedge clock_i);
      miscompares++;
      $display("Error at %0t: run did not finish", $time);
      final_report();
   end

   // test sequence
   initial begin
      rst_n_i = 1'b0;
      avs_address_i = 4'h0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      addr_select_pin_i = 1'b0;
      fuse_status_bits_i = 2'h0;
      prog_cnt = 0;
      addr_seen = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      do_reset();
      check({26'h0, wiper_setting_o}, 32'h20, "wiper at reset");
      bus_read(pot_link_pkg::CODE_OFS, st);
      check(st, 32'h20, "code reg reset");
      bus_read(4'hc, st);
      check(st, 32'h0, "unmapped read");
      // plain writes
      foreach (codes[i]) begin
         xfer(1'b0, 1'b0, 1'b0, codes[i], st);
         check({31'h0, st[1]}, 32'h0, "write acked");
         check({26'h0, wiper_setting_o}, {26'h0, codes[i]}, "wiper");
      end
      // other select level is ignored
      addr_seen = 1'b0;
      xfer(1'b0, 1'b0, 1'b1, 6'h11, st);
      check({31'h0, st[1]}, 32'h1, "mismatch nacked");
      check({26'h0, wiper_setting_o}, 32'h3f, "wiper kept");
      check({31'h0, addr_seen}, 32'h0, "stayed idle");
      // reads under every fuse status
      for (int i = 0; i < 4; i++) begin
         fuse_status_bits_i <= i[1:0];
         xfer(1'b1, 1'b0, 1'b0, 6'h00, st);
         check({24'h0, st[15:8]}, {24'h0, i[1:0], 6'h3f}, "read");
      end
      // select pin high, matching address
      addr_select_pin_i  <= 1'b1;
      fuse_status_bits_i <= 2'h0;
      addr_seen = 1'b0;
      xfer(1'b0, 1'b0, 1'b1, 6'h07, st);
      check({26'h0, wiper_setting_o}, 32'h07, "second address");
      check({31'h0, addr_seen}, 32'h1, "addressed seen");
      check({31'h0, addressed_o}, 32'h0, "released at stop");
      // program request while ready
      prog_cnt = 0;
      xfer(1'b0, 1'b1, 1'b1, 6'h11, st);
      check(prog_cnt, 32'h1, "program pulses");
      check({26'h0, prog_code}, 32'h11, "programmed code");
      bus_read(pot_link_pkg::CTRL_OFS, st);
      check(st, 32'hc, "ctrl readback");
      // after success: acked but ignored
      fuse_status_bits_i <= 2'h3;
      prog_cnt = 0;
      xfer(1'b0, 1'b1, 1'b1, 6'h05, st);
      check({31'h0, st[1]}, 32'h0, "acked after done");
      check({26'h0, wiper_setting_o}, 32'h11, "wiper frozen");
      check(prog_cnt, 32'h0, "no program pulse");
      // second reset mid-run
      do_reset();
      check({26'h0, wiper_setting_o}, 32'h20, "wiper after reset");
      final_report();
   end
endmodule
